// [sensor_regs_pkg.sv]
/*
 * Shared constants and carrier types for the command-response, interrupt-flag
 * and visible-light result register bank.
 * Assumes a single 125 MHz clock and an upstream serial slave that turns host
 * transactions into single-cycle byte register accesses on the same clock.
 */
package sensor_regs_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_COMMAND = 8'h18;
    localparam logic [7:0] ADDR_RESULT_CODE = 8'h20;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h21;
    localparam logic [7:0] ADDR_VIS_LOW = 8'h22;
    localparam logic [7:0] ADDR_VIS_HIGH = 8'h23;

    // ==========================================================
    // values after reset
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [5:0] RESET_FLAGS = 6'h00;
    localparam logic [15:0] RESET_VIS = 16'h0000;

    // ==========================================================
    // interrupt flag positions
    localparam int FLAG_CMD = 5;
    localparam int FLAG_PROX3 = 4;
    localparam int FLAG_PROX2 = 3;
    localparam int FLAG_PROX1 = 2;
    localparam int FLAG_AMBIENT_HI = 1;
    localparam int FLAG_AMBIENT_LO = 0;
    localparam int NUM_FLAGS = 6;

    // ==========================================================
    // result codes; every error code has bit 7 set
    localparam int ERROR_BIT = 7;
    localparam logic [7:0] ERR_INVALID_CMD = 8'h80;
    localparam logic [7:0] ERR_OVF_PROX1 = 8'h88;
    localparam logic [7:0] ERR_OVF_PROX2 = 8'h89;
    localparam logic [7:0] ERR_OVF_PROX3 = 8'h8a;
    localparam logic [7:0] ERR_OVF_VIS = 8'h8c;
    localparam logic [7:0] ERR_OVF_IR = 8'h8d;
    localparam logic [7:0] ERR_OVF_AUX = 8'h8e;
    localparam logic [3:0] COUNT_STEP = 4'h1;

    // ==========================================================
    // locally handled command codes (plain defaults)
    localparam logic [7:0] CMD_NO_OPERATION = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h01;

    // converter overflow source
    typedef enum logic [2:0] {
        OVF_PROX1 = 3'b000,
        OVF_PROX2 = 3'b001,
        OVF_PROX3 = 3'b010,
        OVF_VIS = 3'b011,
        OVF_IR = 3'b100,
        OVF_AUX = 3'b101
    } ovf_src_t;

    // one host register access, valid for one cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // events from the measurement engine, all one-cycle pulses
    typedef struct packed {
        logic ovf;
        ovf_src_t ovf_src;
        logic [2:0] prox_evt;
        logic [1:0] ambient_evt;
        logic vis_valid;
        logic [15:0] vis_data;
        logic auto_clear;
    } meas_evt_t;

endpackage

// [result_code_unit.sv]
/*
 * Command result code register: error latch plus 4-bit completion counter.
 * Assumes clear, write, done and error requests are single-cycle pulses from
 * the register bank on the same clock.
 */
module result_code_unit
    import sensor_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic done,
    input wire logic err_valid,
    input wire logic [7:0] err_code,
    output logic [7:0] code,
    output logic error_held
);

    logic [7:0] next_code;

    // ==========================================================
    // next code: error over clear, clear over write, write over error, error over count
    always_comb begin
        next_code = code;
        if (clear) begin
            next_code = RESET_BYTE;
        end else if (wr_en) begin
            next_code = wr_data;
        end else if (!code[ERROR_BIT] && done) begin
            next_code = {4'h0, code[3:0] + COUNT_STEP};
        end
        // a fresh error lands over a clear in the same cycle, so an error raised
        // just as the host sends a no-operation is never lost
        if (err_valid && (clear || (!wr_en && !code[ERROR_BIT]))) begin
            next_code = err_code;
        end
        // an error sticks until a clear or a host write arrives
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            code <= RESET_BYTE;
        end else begin
            code <= next_code;
        end
    end

    assign error_held = code[ERROR_BIT];

endmodule

// [sensor_cmd_response_irq_regs.sv]
/*
 * Register bank for command mailbox, command result code, interrupt flags
 * and the 16-bit visible-light result.
 * Assumes the serial slave presents byte accesses as REG_REQ pulses on CLK,
 * and that the sequencer and measurement engine run on the same clock.
 */
// Contract
// - A sequencer error loads the result code with bit 7 set.
// - An error stays until reset or no-operation; other commands are dropped. (A host write to 0x20 also replaces it.)
// - A held error never stops measurement events, flags or results.
// - Codes 0x00-0x0F mean no error; low nibble counts finished commands.
// - Command execution may wait an unbounded time for the sequencer.
// - An unrecognised command reports code 0x80.
// - Proximity overflow one, two, three reports 0x88, 0x89, 0x8A.
// - Visible, infrared, auxiliary overflow reports 0x8C, 0x8D, 0x8E.
// - Flags: command bit 5, proximity bits 4..2, ambient 1:0, 7:6 reserved.
// - Interrupt output asserts when any flag and its enable are set.
// - In clearing mode zero a flag stays until host writes one.
// - In mode one flags self-clear except proximity channels in mode 11.
// - Visible result low byte 0x22, high byte 0x23, both zero at reset.
// - Commands enter by writing 0x18; only that write wakes the device.
module sensor_cmd_response_irq_regs
    import sensor_regs_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire reg_req_t REG_REQ,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic CMD_REQ,
    output logic [7:0] CMD_CODE,
    input wire logic CMD_ACK,
    input wire logic CMD_BAD,
    input wire meas_evt_t MEAS_EVT,
    input wire logic [5:0] IRQ_ENABLE,
    input wire logic INT_MODE,
    input wire logic [2:0] PROX_MODE_HOLD,
    output logic IRQ,
    output logic WAKE,
    output logic ERROR_HELD
);

    // ==========================================================
    // register access decode
    logic soft_rst;
    logic rst_any;
    logic wr_cmd;
    logic wr_result;
    logic wr_flags;
    logic wr_vis_low;
    logic wr_vis_high;
    logic is_reset_cmd;
    logic is_nop_cmd;
    logic [7:0] result_code;
    logic error_held;

    // a reset command acts one cycle later through the same path as RST
    assign rst_any = RST | soft_rst;
    assign wr_cmd = REG_REQ.wr && (REG_REQ.addr == ADDR_COMMAND);
    assign wr_result = REG_REQ.wr && (REG_REQ.addr == ADDR_RESULT_CODE);
    assign wr_flags = REG_REQ.wr && (REG_REQ.addr == ADDR_IRQ_FLAGS);
    assign wr_vis_low = REG_REQ.wr && (REG_REQ.addr == ADDR_VIS_LOW);
    assign wr_vis_high = REG_REQ.wr && (REG_REQ.addr == ADDR_VIS_HIGH);
    assign is_reset_cmd = wr_cmd && (REG_REQ.wdata == CMD_RESET);
    assign is_nop_cmd = wr_cmd && (REG_REQ.wdata == CMD_NO_OPERATION);

    // ==========================================================
    // command mailbox towards the sequencer
    logic next_cmd_req;
    logic [7:0] next_cmd_code;
    logic next_wake;
    logic next_soft_rst;
    logic cmd_done;
    logic cmd_invalid;
    logic cmd_taken;

    // a command is taken only with no error held and the mailbox idle;
    // a second write while one is pending is dropped, so the host must
    // wait for the counter to move before issuing the next one
    assign cmd_taken = wr_cmd && !is_reset_cmd && !is_nop_cmd && !error_held && !CMD_REQ;
    assign cmd_done = CMD_REQ && CMD_ACK && !CMD_BAD;
    assign cmd_invalid = CMD_REQ && CMD_ACK && CMD_BAD;

    always_comb begin
        next_cmd_req = CMD_REQ;
        next_cmd_code = CMD_CODE;
        next_wake = wr_cmd;
        next_soft_rst = is_reset_cmd;
        if (CMD_REQ && CMD_ACK) begin
            next_cmd_req = 1'b0; // held until the sequencer gets to it
        end
        if (cmd_taken) begin
            next_cmd_req = 1'b1;
            next_cmd_code = REG_REQ.wdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_any) begin
            CMD_REQ <= 1'b0;
            CMD_CODE <= RESET_BYTE;
            WAKE <= 1'b0;
        end else begin
            CMD_REQ <= next_cmd_req;
            CMD_CODE <= next_cmd_code;
            WAKE <= next_wake;
        end
    end

    // soft reset pulse only depends on RST, never on itself
    always_ff @(posedge CLK) begin
        if (RST) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= next_soft_rst;
        end
    end

    // ==========================================================
    // result code: errors from the sequencer and the converter
    logic err_valid;
    logic [7:0] err_code;

    always_comb begin
        err_valid = 1'b0;
        err_code = ERR_INVALID_CMD;
        if (cmd_invalid) begin
            err_valid = 1'b1;
            err_code = ERR_INVALID_CMD;
        end else if (MEAS_EVT.ovf) begin
            err_valid = 1'b1;
            unique case (MEAS_EVT.ovf_src)
                OVF_PROX1: err_code = ERR_OVF_PROX1;
                OVF_PROX2: err_code = ERR_OVF_PROX2;
                OVF_PROX3: err_code = ERR_OVF_PROX3;
                OVF_VIS: err_code = ERR_OVF_VIS;
                OVF_IR: err_code = ERR_OVF_IR;
                OVF_AUX: err_code = ERR_OVF_AUX;
                default: err_valid = 1'b0; // unused source codes are dropped
            endcase
        end
    end

    result_code_unit u_result (
        .clk(CLK),
        .rst(rst_any),
        .clear(is_nop_cmd),
        .wr_en(wr_result),
        .wr_data(REG_REQ.wdata),
        .done(cmd_done),
        .err_valid(err_valid),
        .err_code(err_code),
        .code(result_code),
        .error_held(error_held)
    );

    // ==========================================================
    // interrupt flags, write-one-to-clear or measurement engine auto-clear
    logic [5:0] flags;
    logic [5:0] next_flags;
    logic [5:0] flag_set;
    logic [5:0] flag_keep;
    logic auto_clr;

    // events land whatever the result code holds
    assign flag_set = {cmd_done | cmd_invalid, MEAS_EVT.prox_evt, MEAS_EVT.ambient_evt};
    assign flag_keep = {1'b0, PROX_MODE_HOLD, 2'b00};
    assign auto_clr = MEAS_EVT.auto_clear && INT_MODE;

    genvar i;
    generate
        for (i = 0; i < NUM_FLAGS; i++) begin : g_flag
            // set beats any clear in the same cycle; zero writes are ignored
            always_comb begin
                next_flags[i] = flags[i];
                if (wr_flags && REG_REQ.wdata[i]) begin
                    next_flags[i] = 1'b0;
                end
                if (auto_clr && !flag_keep[i]) begin
                    next_flags[i] = 1'b0;
                end
                if (flag_set[i]) begin
                    next_flags[i] = 1'b1;
                end
            end
        end
    endgenerate

    logic next_irq;

    // interrupt output is registered from the next flags, so it changes in the same cycle as the flags
    always_comb begin
        next_irq = |(next_flags & IRQ_ENABLE);
    end

    always_ff @(posedge CLK) begin
        if (rst_any) begin
            flags <= RESET_FLAGS;
            IRQ <= 1'b0;
            ERROR_HELD <= 1'b0;
        end else begin
            flags <= next_flags;
            IRQ <= next_irq;
            ERROR_HELD <= result_code[ERROR_BIT];
        end
    end

    // ==========================================================
    // visible light result; engine update beats host write
    logic [15:0] vis;
    logic [15:0] next_vis;

    always_comb begin
        next_vis = vis;
        if (wr_vis_low) begin
            next_vis[7:0] = REG_REQ.wdata;
        end
        if (wr_vis_high) begin
            next_vis[15:8] = REG_REQ.wdata;
        end
        if (MEAS_EVT.vis_valid) begin
            next_vis = MEAS_EVT.vis_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_any) begin
            vis <= RESET_VIS;
        end else begin
            vis <= next_vis;
        end
    end

    // ==========================================================
    // read port: data one cycle after the read strobe
    logic [7:0] next_rd_data;

    always_comb begin
        next_rd_data = RD_DATA;
        if (REG_REQ.rd) begin
            unique case (REG_REQ.addr)
                ADDR_COMMAND: next_rd_data = CMD_CODE;
                ADDR_RESULT_CODE: next_rd_data = result_code;
                ADDR_IRQ_FLAGS: next_rd_data = {2'b00, flags};
                ADDR_VIS_LOW: next_rd_data = vis[7:0];
                ADDR_VIS_HIGH: next_rd_data = vis[15:8];
                default: next_rd_data = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_any) begin
            RD_DATA <= RESET_BYTE;
            RD_VALID <= 1'b0;
        end else begin
            RD_DATA <= next_rd_data;
            RD_VALID <= REG_REQ.rd;
        end
    end

    // ==========================================================
    // checks
    a_error_msb_set: assert property (@(posedge CLK) disable iff (rst_any)
        err_valid && !error_held && !is_nop_cmd && !wr_result |=> result_code[7])
        else $error("error event did not load an error code");

    a_error_retained: assert property (@(posedge CLK) disable iff (rst_any)
        error_held && !is_nop_cmd && !is_reset_cmd && !wr_result
        |=> result_code == $past(result_code))
        else $error("held error code changed without a clear");

    a_error_blocks_cmd: assert property (@(posedge CLK) disable iff (rst_any)
        error_held && wr_cmd && !is_reset_cmd && !is_nop_cmd && !CMD_REQ |=> !CMD_REQ)
        else $error("command accepted while an error was held");

    a_counter_wraps: assert property (@(posedge CLK) disable iff (rst_any)
        cmd_done && !error_held && !err_valid && !is_nop_cmd && !wr_result
        |=> result_code == {4'h0, $past(result_code[3:0]) + 4'h1})
        else $error("completion counter did not advance");

    a_invalid_code: assert property (@(posedge CLK) disable iff (rst_any)
        cmd_invalid && !error_held && !is_nop_cmd && !wr_result |=> result_code == 8'h80)
        else $error("invalid command did not report 0x80");

    a_prox3_overflow: assert property (@(posedge CLK) disable iff (rst_any)
        MEAS_EVT.ovf && MEAS_EVT.ovf_src == OVF_PROX3 && !cmd_invalid && !error_held
        && !is_nop_cmd && !wr_result |=> result_code == 8'h8a)
        else $error("proximity three overflow code wrong");

    a_ir_overflow: assert property (@(posedge CLK) disable iff (rst_any)
        MEAS_EVT.ovf && MEAS_EVT.ovf_src == OVF_IR && !cmd_invalid && !error_held
        && !is_nop_cmd && !wr_result |=> result_code == 8'h8d)
        else $error("infrared overflow code wrong");

    a_flag_set_wins: assert property (@(posedge CLK) disable iff (rst_any)
        MEAS_EVT.prox_evt[0] |=> flags[2] ##1 (flags[2] || $past(wr_flags || auto_clr)))
        else $error("proximity event lost");

    a_irq_follows: assert property (@(posedge CLK) disable iff (rst_any)
        (|(flags & IRQ_ENABLE)) && !wr_flags && !auto_clr |=> IRQ)
        else $error("enabled flag did not raise the interrupt");

    a_write_one_clears: assert property (@(posedge CLK) disable iff (rst_any)
        wr_flags && REG_REQ.wdata[5] && !flag_set[5] |=> !flags[5])
        else $error("write one did not clear the command flag");

    a_write_zero_keeps: assert property (@(posedge CLK) disable iff (rst_any)
        wr_flags && !REG_REQ.wdata[4] && flags[4] && !auto_clr |=> flags[4])
        else $error("write zero disturbed a flag");

    a_mode11_holds: assert property (@(posedge CLK) disable iff (rst_any)
        auto_clr && PROX_MODE_HOLD[1] && flags[3] && !(wr_flags && REG_REQ.wdata[3])
        |=> flags[3])
        else $error("auto clear removed a held proximity flag");

    a_vis_loads: assert property (@(posedge CLK) disable iff (rst_any)
        MEAS_EVT.vis_valid |=> vis == $past(MEAS_EVT.vis_data))
        else $error("visible result not loaded");

    a_wake_on_cmd: assert property (@(posedge CLK) disable iff (rst_any)
        wr_cmd && !is_reset_cmd |=> WAKE ##1 !WAKE || $past(wr_cmd))
        else $error("mailbox write did not pulse wake");

endmodule

// [seq_model.sv]
/*
 * Sequencer stand-in that finishes mailbox commands after a set delay.
 * Assumes CMD_REQ and CMD_CODE come from the register bank on the same clock.
 */
module seq_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [7:0] code,
    input wire logic [7:0] dly,
    output logic ack,
    output logic bad
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_ack;

    // ==========================================================
    // delay counter; the wait stands for a measurement in progress
    always_comb begin
        next_cnt = (rst || !req) ? 8'h00 : cnt + 8'h01;
        next_ack = req && !ack && (cnt == dly);
    end

    always_ff @(posedge clk) begin
        cnt <= next_cnt;
        ack <= next_ack && !rst;
    end

    // codes with bit 7 set are unknown to this sequencer
    assign bad = ack && code[7];
endmodule

// [tb_top.sv]
/*
 * Self-checking bench for the command result, flag and visible result bank.
 * Assumes the sequencer model answers the mailbox; events are driven here.
 */
module tb_top
    import sensor_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst;
    reg_req_t req;
    meas_evt_t ev;
    meas_evt_t e;
    logic [7:0] rd_data, cmd_code, dly, d8, c;
    logic rd_valid, cmd_req, ack, bad, irq, wake, err_held, int_mode;
    logic [5:0] irq_en;
    logic [2:0] hold;
    logic [7:0] expq[$];
    logic [7:0] ovf_tbl[6] = '{8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d, 8'h8e};
    int fail_count = 0;
    int cmp_count = 0;
    int seed = 32'h55f1;

    sensor_cmd_response_irq_regs i_sensor_cmd_response_irq_regs (
        .CLK(clk), .RST(rst), .REG_REQ(req), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .CMD_REQ(cmd_req), .CMD_CODE(cmd_code), .CMD_ACK(ack), .CMD_BAD(bad),
        .MEAS_EVT(ev), .IRQ_ENABLE(irq_en), .INT_MODE(int_mode),
        .PROX_MODE_HOLD(hold), .IRQ(irq), .WAKE(wake), .ERROR_HELD(err_held));

    seq_model i_seq_model (.clk(clk), .rst(rst), .req(cmd_req), .code(cmd_code),
        .dly(dly), .ack(ack), .bad(bad));

    // ==========================================================
    // clock and shared tasks
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic bad_msg(input string m);
        $display("BAD %0t %s", $time, m);
        fail_count++;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] x, input string m);
        cmp_count++;
        if (a !== x) bad_msg(m);
    endtask

    // one idle cycle between accesses keeps every drive single per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) req <= '{1'b1, 1'b0, a, d};
        @(negedge clk) req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        expq.push_back(x);
        @(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) req <= '0;
    endtask

    task automatic pulse(input meas_evt_t p);
        @(negedge clk) ev <= p;
        @(negedge clk) ev <= '0;
    endtask

    // mailbox write, then a bounded wait for the sequencer to finish
    task automatic cmd(input logic [7:0] code);
        int n;
        wr(ADDR_COMMAND, code);
        chk(wake, 8'h01, "no wake pulse");
        n = 0;
        while (cmd_req !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) begin
            bad_msg("command hang");
            results();
        end
        repeat (2) @(negedge clk);
    endtask

    // ==========================================================
    // read monitor: oldest note against each returned byte
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0) begin
                bad_msg("unexpected read data");
            end else begin
                d8 = expq.pop_front();
                cmp_count++;
                if (rd_data !== d8) bad_msg($sformatf("read %h exp %h", rd_data, d8));
            end
        end
    end

    // hang guard
    initial begin
        #400000;
        bad_msg("run timeout");
        results();
    end

    // ==========================================================
    // main sequence
    initial begin
        req = '0;
        ev = '0;
        irq_en = 6'h04;
        int_mode = 1'b0;
        hold = 3'b000;
        dly = 8'h02;
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rd(ADDR_RESULT_CODE, 8'h00);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        rd(ADDR_VIS_LOW, 8'h00);
        rd(ADDR_VIS_HIGH, 8'h00);
        rd(8'h3f, 8'h00);
        // a finished command counts and raises only the command flag
        cmd(8'h05);
        rd(ADDR_RESULT_CODE, 8'h01);
        rd(ADDR_IRQ_FLAGS, 8'h20);
        chk(irq, 8'h00, "irq without enable");
        e = '0;
        e.prox_evt = 3'b001;
        pulse(e);
        chk(irq, 8'h01, "irq missing");
        rd(ADDR_IRQ_FLAGS, 8'h24);
        // zeros and reserved bits change nothing, ones clear
        wr(ADDR_IRQ_FLAGS, 8'h00);
        rd(ADDR_IRQ_FLAGS, 8'h24);
        wr(ADDR_IRQ_FLAGS, 8'hc0);
        rd(ADDR_IRQ_FLAGS, 8'h24);
        wr(ADDR_IRQ_FLAGS, 8'h04);
        chk(irq, 8'h00, "irq not cleared");
        rd(ADDR_IRQ_FLAGS, 8'h20);
        // slow sequencer; a second write while pending is dropped
        dly = 8'h28;
        wr(ADDR_COMMAND, 8'h06);
        cmd(8'h07);
        rd(ADDR_RESULT_CODE, 8'h02);
        chk(cmd_code, 8'h06, "pending code lost");
        wr(ADDR_IRQ_FLAGS, 8'h3f);
        // invalid command latches an error that blocks later commands
        dly = 8'h03;
        cmd(8'h90);
        rd(ADDR_RESULT_CODE, 8'h80);
        chk(err_held, 8'h01, "error not held");
        cmd(8'h05);
        rd(ADDR_RESULT_CODE, 8'h80);
        // measurements carry on under the error
        e = '0;
        e.vis_valid = 1'b1;
        e.vis_data = 16'($random(seed));
        pulse(e);
        rd(ADDR_VIS_LOW, e.vis_data[7:0]);
        rd(ADDR_VIS_HIGH, e.vis_data[15:8]);
        // a host write to the visible result high byte is stored
        wr(ADDR_VIS_HIGH, 8'h5a);
        rd(ADDR_VIS_HIGH, 8'h5a);
        e = '0;
        e.prox_evt = 3'b110;
        e.ambient_evt = 2'b11;
        pulse(e);
        rd(ADDR_IRQ_FLAGS, 8'h3b);
        // ones clear the ambient field, zeros keep the proximity flags
        wr(ADDR_IRQ_FLAGS, 8'h03);
        rd(ADDR_IRQ_FLAGS, 8'h38);
        cmd(CMD_NO_OPERATION);
        rd(ADDR_RESULT_CODE, 8'h00);
        // every overflow source and its code
        for (int i = 0; i < 6; i++) begin
            e = '0;
            e.ovf = 1'b1;
            e.ovf_src = ovf_src_t'(i[2:0]);
            pulse(e);
            rd(ADDR_RESULT_CODE, ovf_tbl[i]);
            cmd(CMD_NO_OPERATION);
        end
        // self clearing only in mode one, held proximity channel kept
        wr(ADDR_IRQ_FLAGS, 8'h3f);
        e = '0;
        e.prox_evt = 3'b111;
        e.ambient_evt = 2'b11;
        pulse(e);
        e = '0;
        e.auto_clear = 1'b1;
        pulse(e);
        rd(ADDR_IRQ_FLAGS, 8'h1f);
        int_mode = 1'b1;
        hold = 3'b010;
        irq_en = 6'h3f;
        pulse(e);
        rd(ADDR_IRQ_FLAGS, 8'h08);
        chk(irq, 8'h01, "held flag lost irq");
        hold = 3'b000;
        pulse(e);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        chk(irq, 8'h00, "irq not self cleared");
        int_mode = 1'b0;
        // soft reset, then the counter rolls over after sixteen commands
        wr(ADDR_RESULT_CODE, 8'h03);
        rd(ADDR_RESULT_CODE, 8'h03);
        wr(ADDR_COMMAND, CMD_RESET);
        rd(ADDR_RESULT_CODE, 8'h00);
        for (int k = 0; k < 16; k++) begin
            dly = {5'h00, 3'($random(seed))} + 8'h01;
            c = {1'b0, 7'($random(seed))} | 8'h02;
            cmd(c);
            rd(ADDR_RESULT_CODE, {4'h0, 4'(k + 1)});
        end
        // the mailbox reads back the last accepted command
        rd(ADDR_COMMAND, c);
        repeat (4) @(negedge clk);
        if (expq.size() != 0) bad_msg("reads left unanswered");
        results();
    end
endmodule
